// ---- abc_adc_model.sv ----
// Purpose: Behavioural model of the bus-port converter, driven by its pins.
// Assumes: Pins are synchronous to clk; conversion shortened to CONV cycles.
// Notes: Floating data lines show the inverse of the result, never the result.
`timescale 1ns/100ps
module abc_adc_model #(
  parameter int CONV = 200, // Conversion cycles
  parameter int TACC = 20 // Bus access cycles
) (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic sel_a_n, // Select A
  input wire logic sel_b_n, // Select B
  input wire logic rd_wr, // Direction
  input wire logic coding_select, // Coding
  input wire logic [7:0] ain, // Input level as a code
  output logic conv_status, // High while converting
  output logic [7:0] adc_data // Data bus
);
  logic s;
  logic rd;
  logic cod_q;
  logic [7:0] res_q;
  logic [7:0] smp_q;
  int lc;
  int cc;
  int ac;
  // ==========================================================
  // Decode of the three control pins
  assign s = !sel_a_n && !sel_b_n && !rd_wr;
  assign rd = !sel_a_n && !sel_b_n && rd_wr && !conv_status;
  // Conversion sequencer and result latch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      conv_status <= 1'b0;
      lc <= 0;
      cc <= 0;
      ac <= 0;
      cod_q <= 1'b0;
      res_q <= 8'h00;
      smp_q <= 8'h00;
    end else begin
      lc <= (s && !conv_status) ? lc + 1 : 0;
      ac <= rd ? ac + 1 : 0;
      if (conv_status) begin
        cc <= cc - 1;
        if (cc == 1) begin
          conv_status <= 1'b0;
          res_q <= cod_q ? smp_q ^ 8'h80 : smp_q;
        end
      end else if (s && lc >= int'(abc_pkg::ABC_TW_CYC) - 1) begin
        conv_status <= 1'b1;
        cc <= CONV;
        smp_q <= ain;
        cod_q <= coding_select;
      end
    end
  end
  // Data drive only in a read after the access time; a floating bus shows the inverse
  assign adc_data = (rd && ac >= TACC) ? res_q : ~res_q;
endmodule

// ---- abc_assertions.sv ----
// Purpose: Pin-level checks on the converter bus controller.
// Assumes: Both selects move together; pins hold while clk_en is low.
// Notes: Run lengths are counted in saturating helper counters.
`timescale 1ns/100ps
module abc_assertions (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic hreadyout, // Slave ready
  input wire logic hresp, // Response
  input wire logic sel_a_n, // Select A
  input wire logic sel_b_n, // Select B
  input wire logic rd_wr, // Direction
  input wire logic polarity_select, // Polarity
  input wire logic coding_select, // Coding
  input wire logic conv_status // Status
);
  import abc_pkg::*;
  logic s;
  logic [10:0] low_q;
  logic [10:0] rd_q;
  logic [10:0] hi_q;
  logic [10:0] sl_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  function automatic logic [10:0] inc(input logic [10:0] v);
    return (v == 11'h7FF) ? v : v + 11'h001;
  endfunction
  // ==========================================================
  // Run lengths of start, read, idle selects and low status
  assign s = !sel_a_n && !rd_wr;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_q <= 11'h000;
      rd_q <= 11'h000;
      hi_q <= 11'h7FF;
      sl_q <= 11'h7FF;
    end else begin
      low_q <= s ? inc(low_q) : 11'h000;
      rd_q <= (!sel_a_n && rd_wr) ? inc(rd_q) : 11'h000;
      hi_q <= sel_a_n ? inc(hi_q) : 11'h000;
      sl_q <= !conv_status ? inc(sl_q) : 11'h000;
    end
  end
  chk_sel_pair: assert property (sel_a_n == sel_b_n)
    else $error("selects differ");
  chk_start_width: assert property (!s && $past(s) |-> low_q >= ABC_TW_CYC)
    else $error("start pulse too short");
  chk_no_start_busy: assert property (s && !$past(s) |-> !$past(conv_status))
    else $error("start while converting");
  chk_read_len: assert property ($rose(sel_a_n) && $past(rd_wr) |-> rd_q >= ABC_TTD_CYC)
    else $error("read shorter than access time");
  chk_float_gap: assert property ($fell(sel_a_n) |-> hi_q >= ABC_TDT_CYC)
    else $error("no float gap before access");
  chk_read_after: assert property ($fell(sel_a_n) && rd_wr |-> sl_q >= ABC_TSD_CYC)
    else $error("read too soon after status low");
  chk_cfg_stable: assert property (s && $past(s) |-> $stable(polarity_select) && $stable(coding_select))
    else $error("selects changed during start");
  chk_single_release: assert property (!s && $past(s) && sel_a_n |-> rd_wr)
    else $error("direction left low after start");
  chk_cont_raise: assert property ($rose(rd_wr) && !sel_a_n |-> $past(conv_status))
    else $error("direction raised with status low");
  chk_cont_len: assert property ($rose(rd_wr) && !sel_a_n |-> low_q >= ABC_TCONT_CYC)
    else $error("direction low too short");
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  cover property (!s && $past(s) && sel_a_n);
  cover property ($rose(rd_wr) && !sel_a_n);
  cover property ($rose(sel_a_n) && $past(rd_wr));
endmodule

bind abc_host abc_assertions u_chk (.clk, .rst, .hreadyout, .hresp, .sel_a_n, .sel_b_n,
  .rd_wr, .polarity_select, .coding_select, .conv_status);

// ---- abc_host.sv ----
// Purpose: Host-side controller driving a bus-port 8-bit converter by its pins.
// Assumes: Converter pins are synchronous to clk; the converter drives the data bus.
// Notes: Software orders conversions and reads results through AHB-Lite registers.
//
// Notes on behaviour
// - Direction low starts, high reads
// - All three low 300 ns starts conversion
// - Data valid 250 ns after read begins
// - Stand-alone single: pulse direction low once
// - Raise direction only while status is high
// - Direction low at least 10.25 us continuous
// - Polarity and coding set before each start; here they change on the same edge that brings the three lows
//
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/100ps
module abc_host (
  input logic clk, // System clock, 125 MHz
  input logic rst, // Async reset, active high
  input logic clk_en, // Freezes all state when low
  input logic hsel, // AHB slave select
  input logic [abc_pkg::ABC_AW-1:0] haddr, // AHB address, low bits
  input logic [1:0] htrans, // AHB transfer type
  input logic hwrite, // AHB write
  input logic [2:0] hsize, // AHB size
  input logic [31:0] hwdata, // AHB write data
  input logic hready, // AHB ready
  output logic hreadyout, // AHB slave ready
  output logic hresp, // AHB response
  output logic [31:0] hrdata, // AHB read data
  output logic sel_a_n, // First converter select, active low
  output logic sel_b_n, // Second converter select, active low
  output logic rd_wr, // Direction: high read, low convert start
  output logic polarity_select, // Bipolar when high
  output logic coding_select, // Two's complement when high
  input logic conv_status, // Converter status, high while converting
  input logic [7:0] adc_data // Converter data bus
);
  import abc_pkg::*;

  // ==========================================================
  // Types and state
  typedef enum logic [3:0] {
    ABC_IDLE,
    ABC_CV_ASSERT,
    ABC_CV_WAIT_HI,
    ABC_CV_WAIT_LO,
    ABC_CONT_RUN,
    ABC_CONT_LAST,
    ABC_SD_WAIT,
    ABC_RD_ACCESS,
    ABC_RD_END
  } abc_state_t;

  abc_state_t st_q, st_d;
  logic [ABC_CNT_W-1:0] cnt_q, cnt_d;
  logic sel_n_q, sel_n_d;
  logic rw_q, rw_d;
  logic pol_q, pol_d, cod_q, cod_d;
  logic [7:0] res_q, res_d;
  logic stb_q, stb_d;
  logic stat_q, stat_d;
  logic single_take, read_take;
  logic single_req, read_req, cont_en, pol_sel, cod_sel;
  logic busy;

  // Both selects move together so either one gates the access
  assign sel_a_n = sel_n_q;
  assign sel_b_n = sel_n_q;
  assign rd_wr = rw_q;
  assign polarity_select = pol_q;
  assign coding_select = cod_q;
  assign busy = (st_q != ABC_IDLE);

  // ==========================================================
  // Register slave
  abc_regs u_regs (
    .clk(clk),
    .rst(rst),
    .clk_en(clk_en),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .busy(busy),
    .conv_seen(stat_q),
    .result(res_q),
    .result_stb(stb_q),
    .single_take(single_take),
    .read_take(read_take),
    .single_req(single_req),
    .read_req(read_req),
    .cont_en(cont_en),
    .pol_sel(pol_sel),
    .cod_sel(cod_sel)
  );

  // ==========================================================
  // Sequencer next values
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q + 1'b1;
    sel_n_d = sel_n_q;
    rw_d = rw_q;
    pol_d = pol_q;
    cod_d = cod_q;
    res_d = res_q;
    stb_d = 1'b0;
    stat_d = conv_status;
    single_take = 1'b0;
    read_take = 1'b0;
    case (st_q)
      ABC_IDLE: begin
        cnt_d = '0;
        // A start or read is only issued while the converter is quiet
        if (!conv_status) begin
          if (cont_en) begin
            // Coding pins change on the same edge that brings the three lows, and hold through the start
            pol_d = pol_sel;
            cod_d = cod_sel;
            sel_n_d = 1'b0;
            rw_d = 1'b0;
            st_d = ABC_CONT_RUN;
          end else if (single_req) begin
            single_take = 1'b1;
            pol_d = pol_sel;
            cod_d = cod_sel;
            sel_n_d = 1'b0;
            rw_d = 1'b0;
            st_d = ABC_CV_ASSERT;
          end else if (read_req) begin
            read_take = 1'b1;
            rw_d = 1'b1;
            sel_n_d = 1'b0;
            st_d = ABC_RD_ACCESS;
          end
        end
      end
      ABC_CV_ASSERT: begin
        // Hold the start lows for the least pulse width, then let go
        // so a long hold cannot turn into back-to-back conversions
        if (cnt_q == ABC_TW_CYC - 1'b1) begin
          sel_n_d = 1'b1;
          rw_d = 1'b1;
          st_d = ABC_CV_WAIT_HI;
        end
      end
      ABC_CV_WAIT_HI: begin
        // Converter raises status once it has begun
        if (conv_status) begin
          st_d = ABC_CV_WAIT_LO;
        end
      end
      ABC_CV_WAIT_LO: begin
        cnt_d = '0;
        if (!conv_status) begin
          st_d = ABC_SD_WAIT;
        end
      end
      ABC_CONT_RUN: begin
        // Keep all lows so the converter repeats; count the low time
        if (cnt_q == ABC_TCONT_CYC) begin
          cnt_d = cnt_q;
        end
        if (!cont_en && cnt_q == ABC_TCONT_CYC && conv_status) begin
          rw_d = 1'b1;
          st_d = ABC_CONT_LAST;
        end
      end
      ABC_CONT_LAST: begin
        // Final conversion runs; selects stay low so data comes out after it
        cnt_d = '0;
        if (!conv_status) begin
          st_d = ABC_SD_WAIT;
        end
      end
      ABC_SD_WAIT: begin
        // Give the result time to settle after status falls
        if (cnt_q == ABC_TSD_CYC - 1'b1) begin
          cnt_d = '0;
          rw_d = 1'b1;
          sel_n_d = 1'b0;
          st_d = ABC_RD_ACCESS;
        end
      end
      ABC_RD_ACCESS: begin
        // Sample only after the full bus access time
        if (cnt_q == ABC_TTD_CYC - 1'b1) begin
          res_d = adc_data;
          stb_d = 1'b1;
          cnt_d = '0;
          sel_n_d = 1'b1;
          st_d = ABC_RD_END;
        end
      end
      ABC_RD_END: begin
        // Let the converter float the bus before anything else
        if (cnt_q == ABC_TDT_CYC - 1'b1) begin
          cnt_d = '0;
          st_d = ABC_IDLE;
        end
      end
      default: begin
        cnt_d = '0;
        sel_n_d = 1'b1;
        rw_d = 1'b1;
        st_d = ABC_IDLE;
      end
    endcase
  end

  // Sequencer register stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= ABC_IDLE;
      cnt_q <= '0;
      sel_n_q <= 1'b1;
      rw_q <= 1'b1;
      pol_q <= 1'b0;
      cod_q <= 1'b0;
      res_q <= 8'h00;
      stb_q <= 1'b0;
      stat_q <= 1'b0;
    end else if (clk_en) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sel_n_q <= sel_n_d;
      rw_q <= rw_d;
      pol_q <= pol_d;
      cod_q <= cod_d;
      res_q <= res_d;
      stb_q <= stb_d;
      stat_q <= stat_d;
    end
  end

endmodule

// ---- abc_pkg.sv ----
// Purpose: Shared constants for the converter bus controller.
// Assumes: 125 MHz system clock; register bus is AHB-Lite with 32-bit data.
// Notes: Pin timing figures are kept in ns; cycle counts are derived from them.
package abc_pkg;

  // ==========================================================
  // Clock and counter sizing
  localparam int ABC_CLK_NS = 8; // Clock period
  localparam int ABC_CNT_W = 11; // Wide enough for the longest count

  // Least time in ns to whole cycles, rounded up, at least one
  function automatic logic [ABC_CNT_W-1:0] abc_ns_to_cyc(input int ns);
    int c;
    c = (ns + ABC_CLK_NS - 1) / ABC_CLK_NS;
    if (c < 1) begin
      c = 1;
    end
    return ABC_CNT_W'(c);
  endfunction

  // ==========================================================
  // Pin timing of the converter
  localparam int ABC_TW_NS = 300; // Start pulse width
  localparam int ABC_TSD_NS = 250; // Status low to data readable
  localparam int ABC_TTD_NS = 250; // Bus access time
  localparam int ABC_TDT_NS = 150; // Output float delay
  localparam int ABC_TCONT_NS = 10250; // Least direction-low time in continuous mode
  localparam logic [ABC_CNT_W-1:0] ABC_TW_CYC = abc_ns_to_cyc(ABC_TW_NS);
  localparam logic [ABC_CNT_W-1:0] ABC_TSD_CYC = abc_ns_to_cyc(ABC_TSD_NS);
  localparam logic [ABC_CNT_W-1:0] ABC_TTD_CYC = abc_ns_to_cyc(ABC_TTD_NS);
  localparam logic [ABC_CNT_W-1:0] ABC_TDT_CYC = abc_ns_to_cyc(ABC_TDT_NS);
  localparam logic [ABC_CNT_W-1:0] ABC_TCONT_CYC = abc_ns_to_cyc(ABC_TCONT_NS);

  // ==========================================================
  // Register map (byte addresses) and fields
  localparam int ABC_AW = 4; // Decoded address bits
  localparam logic [ABC_AW-1:0] ABC_OFS_CTRL = 4'h0;
  localparam logic [ABC_AW-1:0] ABC_OFS_STAT = 4'h4;
  localparam logic [ABC_AW-1:0] ABC_OFS_DATA = 4'h8;
  localparam int ABC_CTRL_SINGLE = 0; // Write 1: one conversion then read
  localparam int ABC_CTRL_CONT = 1; // Level: continuous conversion
  localparam int ABC_CTRL_READ = 2; // Write 1: read only
  localparam int ABC_CTRL_POL = 4; // Polarity select for next start
  localparam int ABC_CTRL_COD = 5; // Coding select for next start
  localparam int ABC_STAT_BUSY = 0;
  localparam int ABC_STAT_CONV = 1;
  localparam int ABC_STAT_VALID = 2; // Write 1 to clear
  localparam int ABC_STAT_SPEND = 3;
  localparam int ABC_STAT_RPEND = 4;
  localparam logic [1:0] ABC_HTRANS_NONSEQ = 2'h2;
  localparam logic [31:0] ABC_ZERO32 = 32'h0000_0000;

endpackage

// ---- abc_regs.sv ----
// Purpose: AHB-Lite register slave for the converter bus controller.
// Assumes: Single word transfers; zero wait states; response always OKAY.
// Notes: Command bits stay pending until the sequencer takes them.
`timescale 1ns/100ps
module abc_regs (
  input logic clk, // System clock
  input logic rst, // Async reset, active high
  input logic clk_en, // Freezes all state when low
  input logic hsel, // Slave select
  input logic [abc_pkg::ABC_AW-1:0] haddr, // Low address bits
  input logic [1:0] htrans, // Transfer type
  input logic hwrite, // Write when high
  input logic [2:0] hsize, // Transfer size, word only
  input logic [31:0] hwdata, // Write data
  input logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic hresp, // Response, always OKAY
  output logic [31:0] hrdata, // Read data
  input logic busy, // Sequencer active
  input logic conv_seen, // Converter status seen
  input logic [7:0] result, // Last captured result
  input logic result_stb, // New result captured
  input logic single_take, // Sequencer took single command
  input logic read_take, // Sequencer took read command
  output logic single_req, // Single conversion pending
  output logic read_req, // Read pending
  output logic cont_en, // Continuous mode on
  output logic pol_sel, // Polarity select setting
  output logic cod_sel // Coding select setting
);
  import abc_pkg::*;

  // ==========================================================
  // Bus phase tracking and registers
  logic wr_q, wr_d;
  logic [ABC_AW-1:0] adr_q, adr_d;
  logic [31:0] rdat_q, rdat_d;
  logic spend_q, spend_d, rpend_q, rpend_d, cont_q, cont_d;
  logic pol_q, pol_d, cod_q, cod_d, valid_q, valid_d;
  logic acc;
  logic [31:0] stat_w;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdat_q;
  assign single_req = spend_q;
  assign read_req = rpend_q;
  assign cont_en = cont_q;
  assign pol_sel = pol_q;
  assign cod_sel = cod_q;

  // Next values: address phase capture, data phase write, hardware set wins
  always_comb begin
    acc = hsel && hready && (htrans == ABC_HTRANS_NONSEQ) && (hsize == 3'h2);
    stat_w = ABC_ZERO32;
    stat_w[ABC_STAT_BUSY] = busy;
    stat_w[ABC_STAT_CONV] = conv_seen;
    stat_w[ABC_STAT_VALID] = valid_q;
    stat_w[ABC_STAT_SPEND] = spend_q;
    stat_w[ABC_STAT_RPEND] = rpend_q;
    wr_d = acc && hwrite;
    adr_d = acc ? haddr : adr_q;
    rdat_d = rdat_q;
    if (acc && !hwrite) begin
      case (haddr)
        ABC_OFS_CTRL: rdat_d = {26'h0, cod_q, pol_q, 2'h0, cont_q, 1'b0};
        ABC_OFS_STAT: rdat_d = stat_w;
        ABC_OFS_DATA: rdat_d = {24'h0, result};
        default: rdat_d = ABC_ZERO32;
      endcase
    end
    spend_d = spend_q && !single_take;
    rpend_d = rpend_q && !read_take;
    cont_d = cont_q;
    pol_d = pol_q;
    cod_d = cod_q;
    valid_d = valid_q;
    if (wr_q && adr_q == ABC_OFS_CTRL) begin
      spend_d = spend_d || hwdata[ABC_CTRL_SINGLE];
      rpend_d = rpend_d || hwdata[ABC_CTRL_READ];
      cont_d = hwdata[ABC_CTRL_CONT];
      pol_d = hwdata[ABC_CTRL_POL];
      cod_d = hwdata[ABC_CTRL_COD];
    end
    if (wr_q && adr_q == ABC_OFS_STAT && hwdata[ABC_STAT_VALID]) begin
      valid_d = 1'b0;
    end
    if (result_stb) begin
      valid_d = 1'b1;
    end
  end

  // Register stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_q <= 1'b0;
      adr_q <= '0;
      rdat_q <= ABC_ZERO32;
      spend_q <= 1'b0;
      rpend_q <= 1'b0;
      cont_q <= 1'b0;
      pol_q <= 1'b0;
      cod_q <= 1'b0;
      valid_q <= 1'b0;
    end else if (clk_en) begin
      wr_q <= wr_d;
      adr_q <= adr_d;
      rdat_q <= rdat_d;
      spend_q <= spend_d;
      rpend_q <= rpend_d;
      cont_q <= cont_d;
      pol_q <= pol_d;
      cod_q <= cod_d;
      valid_q <= valid_d;
    end
  end

endmodule

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the converter bus controller.
// Assumes: One AHB-Lite master; the converter model answers on the pins.
// Notes: Input codes come from a fixed seed.
`timescale 1ns/100ps
module tb_top;
  import abc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [3:0] haddr = 4'h0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [7:0] ain = 8'h00;
  logic [31:0] hrdata, rd, w;
  logic hready, hreadyout, hresp, sel_a_n, sel_b_n, rd_wr;
  logic polarity_select, coding_select, conv_status;
  logic [7:0] adc_data, x;
  int fails = 0;
  int n_tests = 0;
  int seed = 14498;
  // ==========================================================
  // Clock, bus ready and the two parties
  always #4 clk = ~clk;
  assign hready = hreadyout;
  abc_host dut (.clk, .rst, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .sel_a_n, .sel_b_n, .rd_wr, .polarity_select,
    .coding_select, .conv_status, .adc_data);
  abc_adc_model mdl (.clk, .rst, .sel_a_n, .sel_b_n, .rd_wr, .coding_select, .ain,
    .conv_status, .adc_data);
  // ==========================================================
  // Checking, bus and wait tasks
  function automatic logic [31:0] expv(input logic [7:0] v, input logic c);
    return {24'h000000, c ? v ^ 8'h80 : v};
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic hwait;
    int i;
    i = 0;
    @(posedge clk);
    while (hready !== 1'b1) begin
      i++;
      if (i > 100) begin
        fails++;
        stop_test;
      end
      @(posedge clk);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= ABC_HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    hwait;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    hwait;
    rd = hrdata;
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 3000; i++) begin
      bus(1'b0, ABC_OFS_STAT, 32'h0);
      if ((rd & 32'h19) === 32'h0) return;
    end
    fails++;
    stop_test;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check({sel_a_n, sel_b_n, rd_wr, polarity_select, coding_select}, 32'h1C);
    for (int a = 0; a < 16; a += 4) begin
      bus(1'b0, 4'(a), 32'h0);
      check(rd, 32'h0);
    end
    // Single conversions over every coding choice, some queued back to back
    for (int k = 0; k < 8; k++) begin
      x = 8'($random(seed));
      ain <= x;
      w = 32'h1 | (32'(k[1:0]) << ABC_CTRL_POL);
      bus(1'b1, ABC_OFS_CTRL, w);
      if (k[2]) bus(1'b1, ABC_OFS_CTRL, w);
      wait_idle;
      bus(1'b0, ABC_OFS_CTRL, 32'h0);
      check(rd, w & 32'h30);
      bus(1'b0, ABC_OFS_DATA, 32'h0);
      check(rd, expv(x, k[1]));
      bus(1'b0, ABC_OFS_STAT, 32'h0);
      check(rd[ABC_STAT_VALID], 1'b1);
      check(32'({coding_select, polarity_select}), 32'(k[1:0]));
    end
    // Valid flag cleared, then a read-only access of the held result
    bus(1'b1, ABC_OFS_STAT, 32'h4);
    bus(1'b0, ABC_OFS_STAT, 32'h0);
    check(rd[ABC_STAT_VALID], 1'b0);
    ain <= ~x;
    bus(1'b1, ABC_OFS_CTRL, 32'h4);
    wait_idle;
    bus(1'b0, ABC_OFS_DATA, 32'h0);
    check(rd, expv(x, 1'b1));
    // Continuous conversion with the input moving, then one final conversion
    x = 8'($random(seed));
    bus(1'b1, ABC_OFS_CTRL, 32'h22);
    bus(1'b0, ABC_OFS_CTRL, 32'h0);
    check(rd, 32'h22);
    repeat (700) @(posedge clk);
    ain <= x;
    repeat (1000) @(posedge clk);
    bus(1'b1, ABC_OFS_CTRL, 32'h20);
    wait_idle;
    bus(1'b0, ABC_OFS_DATA, 32'h0);
    check(rd, expv(x, 1'b1));
    // Clock enable low: a bus write is lost and the pins hold
    clk_en <= 1'b0;
    bus(1'b1, ABC_OFS_CTRL, 32'h31);
    check({sel_a_n, rd_wr}, 32'h3);
    clk_en <= 1'b1;
    bus(1'b0, ABC_OFS_CTRL, 32'h0);
    check(rd, 32'h20);
    stop_test;
  end
  // Overall run limit
  initial begin
    repeat (100000) @(posedge clk);
    fails++;
    stop_test;
  end
endmodule
